// ==== rtl/rap_consts.svh ====
`ifndef RAP_CONSTS_SVH
`define RAP_CONSTS_SVH

// Register word addresses
`define RAP_ADDR_CTL1L 4'h0
`define RAP_ADDR_CTL1H 4'h1
`define RAP_ADDR_CTL2L 4'h2
`define RAP_ADDR_CTL3L 4'h3
`define RAP_ADDR_STATL 4'h4
`define RAP_ADDR_ALM0 4'h5
`define RAP_ADDR_ALM3 4'h8
`define RAP_ADDR_CAP0 4'h9
`define RAP_ADDR_CAP3 4'hC

// Implemented bits of each word
`define RAP_MASK_CTL1L 16'h86F1
`define RAP_MASK_CTL1H 16'hCFFF
`define RAP_MASK_CTL2L 16'h00C0
`define RAP_MASK_CTL3L 16'hFFFF
`define RAP_MASK_TIMEL 16'h7F00
`define RAP_MASK_TIMEH 16'h3F7F
`define RAP_MASK_DATEL 16'h3F07
`define RAP_MASK_DATEH 16'hFF1F
`define RAP_WORD_ZERO 16'h0000

// Lower control word one
`define RAP_BIT_TS_EN 0
`define RAP_BIT_PIN_OE 7
`define RAP_BIT_PWC_POL 9
`define RAP_BIT_PWC_EN 10
`define RAP_BIT_CAL_EN 15
`define RAP_PIN_OUTPUT_SELECT_HI 6
`define RAP_PIN_OUTPUT_SELECT_LO 4
`define RAP_PIN_OUTPUT_SELECT_PWC 3'h3

// Upper control word one
`define RAP_BIT_ALM_EN 15
`define RAP_BIT_FOREVER 14
`define RAP_ALARM_DIGIT_MASK_HI 11
`define RAP_ALARM_DIGIT_MASK_LO 8
`define RAP_RPT_HI 7
`define RAP_RPT_LO 0

// Other control words and status
`define RAP_PS_HI 7
`define RAP_PS_LO 6
`define RAP_SAMP_HI 15
`define RAP_SAMP_LO 8
`define RAP_STAB_HI 7
`define RAP_STAB_LO 0
`define RAP_BIT_TS_FLAG 3

// Counts and limits
`define RAP_CNT_ZERO 8'h00
`define RAP_CNT_ONE 8'h01
`define RAP_CNT_FULL 8'hFF
`define RAP_PS_DIV1 8'h00
`define RAP_PS_DIV16 8'h0F
`define RAP_PS_DIV64 8'h3F
`define RAP_PS_DIV256 8'hFF

// Alarm mask codes
`define RAP_AM_HALFSEC 4'h0
`define RAP_AM_SEC 4'h1
`define RAP_AM_10SEC 4'h2
`define RAP_AM_MIN 4'h3
`define RAP_AM_10MIN 4'h4
`define RAP_AM_HOUR 4'h5
`define RAP_AM_DAY 4'h6
`define RAP_AM_WEEK 4'h7
`define RAP_AM_MONTH 4'h8
`define RAP_AM_YEAR 4'h9

`endif

// ==== rtl/rap_pkg.sv ====
package rap_pkg;

typedef enum logic [1:0] {
    RAP_PWC_IDLE = 2'b00,
    RAP_PWC_STAB = 2'b01,
    RAP_PWC_SAMP = 2'b10
} rap_pwc_state_type;

typedef struct packed {
    logic [15:0] ctl1l;
    logic [15:0] ctl1h;
    logic [15:0] ctl2l;
    logic [15:0] ctl3l;
    logic ts_flag;
    logic [3:0][15:0] alm_val;
    logic tamper_prev;
    logic [7:0] presc_cnt;
    logic [7:0] win_cnt;
    rap_pwc_state_type pwc_state;
    logic [15:0] rd_data;
    logic alarm_pulse;
    logic ts_pulse;
    logic pin_out;
    logic pin_oe;
    logic sample_gate;
    logic stab_window;
} rap_state_type;

endpackage

// ==== rtl/rap_top.sv ====
// The plain strobed port and the placing of the registers were left to the implementer.
`include "rap_consts.svh"

module rap_top
    import rap_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic por_b,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic cal_tick,
    input wire logic pwc_clk_tick,
    input wire logic [15:0] cal_time_low,
    input wire logic [15:0] cal_time_high,
    input wire logic [15:0] cal_date_low,
    input wire logic [15:0] cal_date_high,
    input wire logic tamper_input,
    output logic alarm_irq,
    output logic timestamp_irq,
    output logic clock_pin_out,
    output logic clock_pin_oe,
    output logic sample_gate,
    output logic stability_window
);

    rap_state_type state_reg;
    rap_state_type state_next;
    logic [3:0][15:0] cap_reg;
    logic [3:0][15:0] cap_next;
    logic [3:0][15:0] cal_now;
    logic [3:0][15:0] word_mask;
    logic capture_now;

    assign cal_now = {cal_date_high, cal_date_low, cal_time_high,
                      cal_time_low};
    assign word_mask = {`RAP_MASK_DATEH, `RAP_MASK_DATEL,
                        `RAP_MASK_TIMEH, `RAP_MASK_TIMEL};

    function automatic logic [7:0] presc_limit(input logic [1:0] sel);
        case (sel)
            2'd0: presc_limit = `RAP_PS_DIV1;
            2'd1: presc_limit = `RAP_PS_DIV16;
            2'd2: presc_limit = `RAP_PS_DIV64;
            default: presc_limit = `RAP_PS_DIV256;
        endcase
    endfunction

    // Digit fields: 0 time low, 1 time high, 2 date low, 3 date high
    function automatic logic alarm_match(
        input logic [3:0] alarm_digit_mask,
        input logic [3:0][15:0] cal,
        input logic [3:0][15:0] alm
    );
        logic sec1;
        logic sec;
        logic min1;
        logic min;
        logic hour;
        logic wday;
        logic day;
        logic month;
        sec1 = cal[0][11:8] == alm[0][11:8];
        sec = sec1 && (cal[0][14:12] == alm[0][14:12]);
        min1 = sec && (cal[1][3:0] == alm[1][3:0]);
        min = min1 && (cal[1][6:4] == alm[1][6:4]);
        hour = min && (cal[1][13:8] == alm[1][13:8]);
        wday = hour && (cal[2][2:0] == alm[2][2:0]);
        day = hour && (cal[2][13:8] == alm[2][13:8]);
        month = day && (cal[3][4:0] == alm[3][4:0]);
        case (alarm_digit_mask)
            `RAP_AM_HALFSEC: alarm_match = 1'b1;
            `RAP_AM_SEC: alarm_match = 1'b1;
            `RAP_AM_10SEC: alarm_match = sec1;
            `RAP_AM_MIN: alarm_match = sec;
            `RAP_AM_10MIN: alarm_match = min1;
            `RAP_AM_HOUR: alarm_match = min;
            `RAP_AM_DAY: alarm_match = hour;
            `RAP_AM_WEEK: alarm_match = wday;
            `RAP_AM_MONTH: alarm_match = day;
            `RAP_AM_YEAR: alarm_match = month;
            default: alarm_match = 1'b0;
        endcase
    endfunction

    always_comb
    begin
        logic alm_en;
        logic forever_on;
        logic [7:0] rpt;
        logic alarm_fire;
        logic ts_en;
        logic tamper_fall;
        logic sw_req;
        logic flag_clr;
        logic pwc_tick;
        logic [7:0] samp_len;
        logic [7:0] stab_len;
        logic pwc_on;
        logic [3:0] idx;
        alm_en = 1'b0;
        forever_on = 1'b0;
        rpt = `RAP_CNT_ZERO;
        alarm_fire = 1'b0;
        ts_en = 1'b0;
        tamper_fall = 1'b0;
        sw_req = 1'b0;
        flag_clr = 1'b0;
        pwc_tick = 1'b0;
        samp_len = `RAP_CNT_ZERO;
        stab_len = `RAP_CNT_ZERO;
        pwc_on = 1'b0;
        idx = 4'h0;
        state_next = state_reg;
        cap_next = cap_reg;
        capture_now = 1'b0;

        // Register writes
        if (reg_wr)
        begin
            case (reg_addr)
                `RAP_ADDR_CTL1L:
                    state_next.ctl1l = reg_wdata & `RAP_MASK_CTL1L;
                `RAP_ADDR_CTL1H:
                    state_next.ctl1h = reg_wdata & `RAP_MASK_CTL1H;
                `RAP_ADDR_CTL2L:
                    state_next.ctl2l = reg_wdata & `RAP_MASK_CTL2L;
                `RAP_ADDR_CTL3L:
                    state_next.ctl3l = reg_wdata & `RAP_MASK_CTL3L;
                default:
                begin
                    if (reg_addr >= `RAP_ADDR_ALM0 &&
                        reg_addr <= `RAP_ADDR_ALM3)
                    begin
                        idx = reg_addr - `RAP_ADDR_ALM0;
                        state_next.alm_val[idx[1:0]] =
                            reg_wdata & word_mask[idx[1:0]];
                    end
                end
            endcase
        end

        ts_en = state_reg.ctl1l[`RAP_BIT_TS_EN];
        if (reg_wr && reg_addr == `RAP_ADDR_STATL)
        begin
            flag_clr = !reg_wdata[`RAP_BIT_TS_FLAG];
            sw_req = reg_wdata[`RAP_BIT_TS_FLAG] && ts_en;
        end

        // General storage only while timestamping is off
        if (reg_wr && !ts_en && reg_addr >= `RAP_ADDR_CAP0 &&
            reg_addr <= `RAP_ADDR_CAP3)
        begin
            idx = reg_addr - `RAP_ADDR_CAP0;
            cap_next[idx[1:0]] = reg_wdata & word_mask[idx[1:0]];
        end

        // Timestamp capture
        state_next.tamper_prev = tamper_input;
        tamper_fall = state_reg.tamper_prev && !tamper_input;
        capture_now = !state_reg.ts_flag &&
                      ((ts_en && tamper_fall) || sw_req);
        if (flag_clr)
        begin
            state_next.ts_flag = 1'b0;
        end
        if (capture_now)
        begin
            cap_next = cal_now & word_mask;
            state_next.ts_flag = 1'b1;
        end
        state_next.ts_pulse = capture_now;

        // Alarm
        alm_en = state_reg.ctl1h[`RAP_BIT_ALM_EN];
        forever_on = state_reg.ctl1h[`RAP_BIT_FOREVER];
        rpt = state_reg.ctl1h[`RAP_RPT_HI:`RAP_RPT_LO];
        alarm_fire = cal_tick && alm_en &&
                     state_reg.ctl1l[`RAP_BIT_CAL_EN] &&
                     alarm_match(state_reg.ctl1h[`RAP_ALARM_DIGIT_MASK_HI:`RAP_ALARM_DIGIT_MASK_LO],
                                 cal_now, state_reg.alm_val);
        state_next.alarm_pulse = alarm_fire;
        if (alarm_fire)
        begin
            if (rpt != `RAP_CNT_ZERO)
            begin
                state_next.ctl1h[`RAP_RPT_HI:`RAP_RPT_LO] =
                    rpt - `RAP_CNT_ONE;
            end
            else if (forever_on)
            begin
                state_next.ctl1h[`RAP_RPT_HI:`RAP_RPT_LO] =
                    `RAP_CNT_FULL;
            end
            else
            begin
                state_next.ctl1h[`RAP_BIT_ALM_EN] = 1'b0;
            end
        end

        // Power-control prescaler
        if (pwc_clk_tick)
        begin
            if (state_reg.presc_cnt >=
                presc_limit(state_reg.ctl2l[`RAP_PS_HI:`RAP_PS_LO]))
            begin
                state_next.presc_cnt = `RAP_CNT_ZERO;
                pwc_tick = 1'b1;
            end
            else
            begin
                state_next.presc_cnt = state_reg.presc_cnt + `RAP_CNT_ONE;
            end
        end

        // Power-control windows
        samp_len = state_reg.ctl3l[`RAP_SAMP_HI:`RAP_SAMP_LO];
        stab_len = state_reg.ctl3l[`RAP_STAB_HI:`RAP_STAB_LO];
        case (state_reg.pwc_state)
            RAP_PWC_IDLE:
            begin
                if (alarm_fire && state_reg.ctl1l[`RAP_BIT_PWC_EN])
                begin
                    if (stab_len != `RAP_CNT_ZERO)
                    begin
                        state_next.pwc_state = RAP_PWC_STAB;
                        state_next.win_cnt = stab_len;
                    end
                    else if (samp_len != `RAP_CNT_ZERO)
                    begin
                        state_next.pwc_state = RAP_PWC_SAMP;
                        state_next.win_cnt = samp_len;
                    end
                end
            end
            RAP_PWC_STAB:
            begin
                if (pwc_tick)
                begin
                    if (state_reg.win_cnt > `RAP_CNT_ONE)
                    begin
                        state_next.win_cnt =
                            state_reg.win_cnt - `RAP_CNT_ONE;
                    end
                    else if (samp_len != `RAP_CNT_ZERO)
                    begin
                        state_next.pwc_state = RAP_PWC_SAMP;
                        state_next.win_cnt = samp_len;
                    end
                    else
                    begin
                        state_next.pwc_state = RAP_PWC_IDLE;
                        state_next.win_cnt = `RAP_CNT_ZERO;
                    end
                end
            end
            RAP_PWC_SAMP:
            begin
                if (pwc_tick)
                begin
                    if (state_reg.win_cnt > `RAP_CNT_ONE)
                    begin
                        state_next.win_cnt =
                            state_reg.win_cnt - `RAP_CNT_ONE;
                    end
                    else
                    begin
                        state_next.pwc_state = RAP_PWC_IDLE;
                        state_next.win_cnt = `RAP_CNT_ZERO;
                    end
                end
            end
            default:
            begin
                state_next.pwc_state = RAP_PWC_IDLE;
                state_next.win_cnt = `RAP_CNT_ZERO;
            end
        endcase

        // Window, gate and pin level follow the next state so they line up with it
        pwc_on = state_next.pwc_state != RAP_PWC_IDLE;
        state_next.stab_window = pwc_on ||
            (stab_len == `RAP_CNT_FULL);
        state_next.sample_gate =
            state_next.pwc_state == RAP_PWC_SAMP;
        state_next.pin_oe = state_reg.ctl1l[`RAP_BIT_PIN_OE] &&
            (state_reg.ctl1l[`RAP_PIN_OUTPUT_SELECT_HI:`RAP_PIN_OUTPUT_SELECT_LO] ==
             `RAP_PIN_OUTPUT_SELECT_PWC);
        state_next.pin_out = state_next.pin_oe &&
            (pwc_on == state_reg.ctl1l[`RAP_BIT_PWC_POL]);

        // Read data, one cycle after the strobe
        state_next.rd_data = `RAP_WORD_ZERO;
        if (reg_rd)
        begin
            case (reg_addr)
                `RAP_ADDR_CTL1L: state_next.rd_data = state_reg.ctl1l;
                `RAP_ADDR_CTL1H: state_next.rd_data = state_reg.ctl1h;
                `RAP_ADDR_CTL2L: state_next.rd_data = state_reg.ctl2l;
                `RAP_ADDR_CTL3L: state_next.rd_data = state_reg.ctl3l;
                `RAP_ADDR_STATL:
                    state_next.rd_data[`RAP_BIT_TS_FLAG] = state_reg.ts_flag;
                default:
                begin
                    if (reg_addr >= `RAP_ADDR_ALM0 &&
                        reg_addr <= `RAP_ADDR_ALM3)
                    begin
                        idx = reg_addr - `RAP_ADDR_ALM0;
                        state_next.rd_data = state_reg.alm_val[idx[1:0]];
                    end
                    else if (reg_addr >= `RAP_ADDR_CAP0 &&
                             reg_addr <= `RAP_ADDR_CAP3)
                    begin
                        idx = reg_addr - `RAP_ADDR_CAP0;
                        state_next.rd_data = cap_reg[idx[1:0]];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= '0;
            state_reg.tamper_prev <= 1'b1;
            state_reg.pwc_state <= RAP_PWC_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Cleared only by power-on reset
    always_ff @(posedge sys_clk or negedge por_b)
    begin
        if (!por_b)
        begin
            cap_reg <= '0;
        end
        else
        begin
            cap_reg <= cap_next;
        end
    end

    assign reg_rdata = state_reg.rd_data;
    assign alarm_irq = state_reg.alarm_pulse;
    assign timestamp_irq = state_reg.ts_pulse;
    assign clock_pin_out = state_reg.pin_out;
    assign clock_pin_oe = state_reg.pin_oe;
    assign sample_gate = state_reg.sample_gate;
    assign stability_window = state_reg.stab_window;

endmodule

// ==== verification/rap_checker.sv ====
module rap_checker
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic reg_wr,
    input wire logic cal_tick,
    input wire logic pwc_clk_tick,
    input wire logic tamper_input,
    input wire logic alarm_irq,
    input wire logic timestamp_irq,
    input wire logic clock_pin_out,
    input wire logic clock_pin_oe,
    input wire logic sample_gate,
    input wire logic stability_window
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    alarm_cause_a: assert property (
        alarm_irq |-> $past(cal_tick))
        else $error("alarm pulse without calendar tick");
    stamp_once_a: assert property (
        timestamp_irq |=> !timestamp_irq)
        else $error("second capture while event flag set");
    stamp_cause_a: assert property (
        timestamp_irq |-> $past(reg_wr) ||
        ($past(tamper_input, 2) && !$past(tamper_input)))
        else $error("capture without tamper fall or request");
    pin_idle_a: assert property (
        !clock_pin_oe |-> !clock_pin_out)
        else $error("pin level while output disabled");
    gate_inside_a: assert property (
        sample_gate |-> stability_window)
        else $error("sample gate outside window");
    gate_open_a: assert property (
        $rose(sample_gate) |-> $past(pwc_clk_tick) || $past(cal_tick))
        else $error("sample gate opened off a tick");
    gate_close_a: assert property (
        $fell(sample_gate) |-> $past(pwc_clk_tick))
        else $error("sample gate closed off a tick");
    window_cause_a: assert property (
        $rose(stability_window) |-> $past(cal_tick) || $past(reg_wr, 2))
        else $error("window opened without cause");
    window_alarm_a: assert property (
        $rose(stability_window) && $past(cal_tick) |-> alarm_irq)
        else $error("power cycle started without alarm");
endmodule

bind rap_top rap_checker chk_u (.sys_clk(sys_clk), .rst_b(rst_b),
    .reg_wr(reg_wr), .cal_tick(cal_tick), .pwc_clk_tick(pwc_clk_tick),
    .tamper_input(tamper_input), .alarm_irq(alarm_irq),
    .timestamp_irq(timestamp_irq), .clock_pin_out(clock_pin_out),
    .clock_pin_oe(clock_pin_oe), .sample_gate(sample_gate),
    .stability_window(stability_window));

// ==== verification/rap_ext_dev.sv ====
module rap_ext_dev
(
    input wire logic sys_clk,
    input wire logic fire,
    input wire logic pol,
    input wire logic pin_out,
    input wire logic pin_oe,
    input wire logic sample_gate,
    output logic tamper_input,
    output int wake_count,
    output int gate_faults
);
    timeunit 1ns;
    timeprecision 1ps;
    int low_left = 0;
    logic was_on = 1'b0;
    logic on;
    initial
    begin
        tamper_input = 1'b1;
        wake_count = 0;
        gate_faults = 0;
    end
    // Load powered only while its switch is driven active
    assign on = pin_oe && (pin_out === pol);
    always @(posedge sys_clk)
    begin
        was_on <= on;
        if (on && !was_on)
            wake_count <= wake_count + 1;
        if (sample_gate && !on)
            gate_faults <= gate_faults + 1;
        low_left <= fire ? 3 : (low_left > 0 ? low_left - 1 : 0);
        tamper_input <= !(fire || low_left > 1);
    end
endmodule

// ==== verification/rap_top_tb.sv ====
module rap_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic por_b = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic cal_tick = 1'b0;
    logic tk = 1'b0;
    logic fire = 1'b0;
    logic pol = 1'b0;
    logic [15:0] cw [4] = '{default: 16'h0000};
    logic [15:0] reg_rdata, d;
    logic tamper_input, alarm_irq, timestamp_irq, pin, oe, gate, stab;
    logic [15:0] cap_m [4];
    logic [15:0] msk [4] = '{16'h86F1, 16'hCFFF, 16'h00C0, 16'hFFFF};
    logic [15:0] cmsk [4] = '{16'h7F00, 16'h3F7F, 16'h3F07, 16'hFF1F};
    int dv [4] = '{1, 16, 64, 256};
    int miscompares = 0;
    int check_count = 0;
    int seed = 99;
    int cyc = 0;
    int ts_seen = 0;
    int wakes, gfaults;

    always #10 sys_clk = ~sys_clk;

    rap_top dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .por_b(por_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cal_tick(cal_tick),
        .pwc_clk_tick(tk), .cal_time_low(cw[0]), .cal_time_high(cw[1]),
        .cal_date_low(cw[2]), .cal_date_high(cw[3]),
        .tamper_input(tamper_input), .alarm_irq(alarm_irq),
        .timestamp_irq(timestamp_irq), .clock_pin_out(pin),
        .clock_pin_oe(oe), .sample_gate(gate), .stability_window(stab));

    rap_ext_dev ext_u (.sys_clk(sys_clk), .fire(fire), .pol(pol),
        .pin_out(pin), .pin_oe(oe), .sample_gate(gate),
        .tamper_input(tamper_input), .wake_count(wakes),
        .gate_faults(gfaults));

    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        tk <= cyc[0];
        if (timestamp_irq)
            ts_seen <= ts_seen + 1;
        if (cyc == 40000)
        begin
            miscompares++;
            final_report();
        end
    end

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [15:0] e, g);
        check_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rdc(input logic [3:0] a, input logic [15:0] e,
        input string nm);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        cmp(nm, e, reg_rdata);
        @(posedge sys_clk);
    endtask

    task automatic chk_cap;
        for (int i = 0; i < 4; i++)
            rdc(4'h9 + 4'(i), cap_m[i], "captured");
    endtask

    // Alarm model: count, wrap and self-disable per tick
    task automatic alarm_run(input int code, rpt, input bit fe,
        input int n, input bit hit);
        int cnt;
        bit en;
        cnt = rpt;
        en = 1'b1;
        wr(4'h1, {1'b1, fe, 2'b00, code[3:0], rpt[7:0]});
        for (int i = 0; i < n; i++)
        begin
            cal_tick <= 1'b1;
            @(posedge sys_clk);
            cal_tick <= 1'b0;
            @(negedge sys_clk);
            cmp("alarm irq", 16'(en & hit), 16'(alarm_irq));
            @(posedge sys_clk);
            if (en & hit)
            begin
                if (cnt > 0)
                    cnt--;
                else if (fe)
                    cnt = 255;
                else
                    en = 1'b0;
            end
        end
        rdc(4'h1, {en, fe, 2'b00, code[3:0], cnt[7:0]}, "ctl upper");
        wr(4'h1, 16'h0000);
    endtask

    task automatic pwc_run(input int c, sb, sp);
        int ns, ng, on;
        ns = 0;
        ng = 0;
        on = 0;
        pol <= c[0];
        wr(4'h0, 16'h8000);
        wr(4'h0, 16'h8400);
        wr(4'h0, {6'h21, c[0], 9'h0B0});
        wr(4'h2, {8'h00, c[1:0], 6'h00});
        wr(4'h3, {sp[7:0], sb[7:0]});
        wr(4'h1, 16'hC000);
        @(negedge sys_clk);
        cmp("idle pin", 16'(!c[0]), 16'(pin));
        @(posedge sys_clk);
        cal_tick <= 1'b1;
        @(posedge sys_clk);
        cal_tick <= 1'b0;
        for (int i = 0; i < 4000 && !(on && !stab); i++)
        begin
            @(negedge sys_clk);
            on |= stab;
            ns += tk & stab & !gate;
            ng += tk & gate;
            if (stab)
                cmp("active pin", 16'(c[0]), 16'(pin));
        end
        @(posedge sys_clk);
        cmp("stab ticks", 16'h0001,
            16'(ns > dv[c] * (sb - 1) && ns <= dv[c] * sb));
        cmp("gate ticks", 16'(dv[c] * sp), 16'(ng));
        cmp("off pin", 16'(!c[0]), 16'(pin));
        wr(4'h1, 16'h0000);
        wr(4'h0, 16'h0000);
    endtask

    initial
    begin
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        por_b <= 1'b1;
        @(posedge sys_clk);
        for (int a = 0; a < 5; a++)
            rdc(4'(a), 16'h0000, "reset value");
        wr(4'hD, 16'hFFFF);
        rdc(4'hD, 16'h0000, "unmapped");
        for (int a = 0; a < 4; a++)
        begin
            d = $random(seed);
            wr(4'(a), d);
            rdc(4'(a), d & msk[a], "ctl word");
            wr(4'(a), 16'h0000);
        end
        wr(4'h0, 16'h8000);
        alarm_run(0, 0, 0, 3, 1);
        alarm_run(1, 2, 0, 5, 1);
        alarm_run(0, 255, 0, 257, 1);
        alarm_run(1, 1, 1, 6, 1);
        wr(4'h5, 16'h3700);
        cw[0] <= 16'h3700;
        alarm_run(3, 0, 0, 1, 1);
        cw[0] <= 16'h3600;
        alarm_run(3, 0, 0, 2, 0);
        alarm_run(15, 0, 0, 2, 0);
        cw[0] <= 16'h3700;
        cw[2] <= 16'h0001;
        cw[3] <= 16'h0001;
        alarm_run(5, 0, 0, 1, 1);
        alarm_run(6, 0, 0, 1, 1);
        alarm_run(7, 0, 0, 1, 0);
        alarm_run(9, 0, 0, 1, 0);
        wr(4'h0, 16'h0000);
        alarm_run(0, 0, 0, 1, 0);
        wr(4'h0, 16'h8001);
        for (int i = 0; i < 4; i++)
        begin
            cap_m[i] = $random(seed) & cmsk[i];
            cw[i] <= cap_m[i];
        end
        fire <= 1'b1;
        @(posedge sys_clk);
        fire <= 1'b0;
        repeat (8) @(posedge sys_clk);
        cmp("stamp irqs", 16'h0001, ts_seen[15:0]);
        rdc(4'h4, 16'h0008, "event flag");
        chk_cap();
        for (int i = 0; i < 4; i++)
            cw[i] <= ~cap_m[i] & cmsk[i];
        fire <= 1'b1;
        @(posedge sys_clk);
        fire <= 1'b0;
        wr(4'h4, 16'h0008);
        repeat (8) @(posedge sys_clk);
        cmp("stamp irqs", 16'h0001, ts_seen[15:0]);
        chk_cap();
        wr(4'h4, 16'h0000);
        rdc(4'h4, 16'h0000, "event flag");
        for (int i = 0; i < 4; i++)
            cap_m[i] = ~cap_m[i] & cmsk[i];
        wr(4'h4, 16'h0008);
        rdc(4'h4, 16'h0008, "event flag");
        chk_cap();
        wr(4'h4, 16'h0000);
        wr(4'h0, 16'h0000);
        for (int i = 0; i < 4; i++)
        begin
            cap_m[i] = $random(seed);
            wr(4'h9 + 4'(i), cap_m[i]);
            cap_m[i] &= cmsk[i];
        end
        rst_b <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        chk_cap();
        for (int c = 0; c < 4; c++)
            pwc_run(c, 2, 1);
        pwc_run(0, 0, 2);
        cmp("wakes", 16'h0005, wakes[15:0]);
        cmp("gate faults", 16'h0000, gfaults[15:0]);
        wr(4'h0, 16'h8000);
        wr(4'h3, 16'h00FF);
        @(negedge sys_clk);
        cmp("stab held", 16'h0001, 16'(stab));
        final_report();
    end
endmodule
